// ==== rtl/capture_compare_channels.sv ====
`timescale 1ns/1ps
`include "ccu_params.svh"
module capture_compare_channels (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] count_val,
   input  wire logic        count_step,
   input  wire logic        period_match_pulse,
   input  wire logic        wrap_pulse,
   input  wire logic        timer_clear,
   input  wire logic [6:0]  sample_source_a,
   input  wire logic [6:0]  sample_source_b,
   input  wire logic        irq0_ack,
   output logic      [6:0]  chan_wave_pin,
   output logic      [6:0]  chan_match_pulse,
   output logic             irq_ch0,
   output logic             irq_shared
);
   localparam int N = `CCU_NCH;

   ccu_pkg::chan_cfg_t  cfg_ff   [N];
   ccu_pkg::chan_cfg_t  nxt_cfg  [N];
   logic [15:0]         value_ff [N];
   logic [15:0]         nxt_value[N];
   logic [N-1:0]        flag_ff, nxt_flag, lost_ff, nxt_lost, latch_ff, nxt_latch;
   logic [N-1:0]        unread_ff, nxt_unread, pin_ff, nxt_pin, match_ff, nxt_match;
   logic [N-1:0]        prev_ff, nxt_prev, edge_dly_ff, nxt_edge_dly;
   logic [N-1:0]        a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff;
   logic [N-1:0]        sel_lvl, edge_now, cap_evt, match_now;
   logic                wrap_flag_ff, nxt_wrap_flag, wrap_ie_ff, nxt_wrap_ie, gie_ff, nxt_gie;
   logic                irq0_ff, nxt_irq0, irqs_ff, nxt_irqs, pready_ff, nxt_pready, err_ff, nxt_err;
   logic [31:0]         rdata_ff, nxt_rdata;
   ccu_pkg::apb_state_t state_ff, nxt_state;
   logic [6:0]          pend;
   logic [3:0]          vec;
   logic [5:0]          idx;
   logic                acc, wr, rd, hit;

   // priority encoder: bit 0 is channel 1 (highest), bit 6 is the wrap flag
   function automatic logic [3:0] vec_code(input logic [6:0] p);
      logic [3:0] v;
      v = `CCU_VEC_NONE;
      for (int k = 6; k >= 0; k--)
      begin
         if (p[k])
            v = 4'((k + 1) * 2);
      end
      return v;
   endfunction : vec_code

   function automatic logic [15:0] pack_ctl(input ccu_pkg::chan_cfg_t c, input logic lvl,
                                            input logic lat, input logic lst, input logic flg);
      logic [15:0] w;
      w = `CCU_RST_WORD;
      w[`CCU_F_EDGE+:2]   = c.edge_sel;
      w[`CCU_F_INSEL+:2]  = c.insel;
      w[`CCU_F_SYNC]      = c.sync_en;
      w[`CCU_F_LATCH]     = lat;
      w[`CCU_F_MEAS]      = c.meas;
      w[`CCU_F_WMODE+:3]  = c.wmode;
      w[`CCU_F_IE]        = c.ie;
      w[`CCU_F_LEVEL]     = lvl;
      w[`CCU_F_MANUAL]    = c.manual;
      w[`CCU_F_LOST]      = lst;
      w[`CCU_F_FLAG]      = flg;
      return w;
   endfunction : pack_ctl

   // source pins cross in through two flops before any logic sees them
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         a_s1_ff <= '0;
         a_s2_ff <= '0;
         b_s1_ff <= '0;
         b_s2_ff <= '0;
      end
      else if (ce)
      begin
         a_s1_ff <= sample_source_a;
         a_s2_ff <= a_s1_ff;
         b_s1_ff <= sample_source_b;
         b_s2_ff <= b_s1_ff;
      end
   end

   // per-channel events, no state
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         case (cfg_ff[i].insel)
            `CCU_SEL_A:   sel_lvl[i] = a_s2_ff[i];
            `CCU_SEL_B:   sel_lvl[i] = b_s2_ff[i];
            `CCU_SEL_GND: sel_lvl[i] = 1'b0;
            default:      sel_lvl[i] = 1'b1;
         endcase
         // a select change between ground and supply shows up as an edge here
         edge_now[i] = cfg_ff[i].meas &
                       ((cfg_ff[i].edge_sel[`CCU_EDGE_RISE] & sel_lvl[i] & ~prev_ff[i]) |
                        (cfg_ff[i].edge_sel[`CCU_EDGE_FALL] & ~sel_lvl[i] & prev_ff[i]));
         cap_evt[i] = cfg_ff[i].sync_en ? edge_dly_ff[i] : edge_now[i];
         // equality checked only on an advance, so a direct count write alone never matches, and
         // either direction behaves as the counter counting into the value
         match_now[i] = ~cfg_ff[i].meas & count_step & (count_val == value_ff[i]);
      end
      for (int k = 1; k < N; k++)
      begin
         pend[k-1] = flag_ff[k] & cfg_ff[k].ie;
      end
      pend[6] = wrap_flag_ff & wrap_ie_ff;
      vec = vec_code(pend);
   end

   always_comb
   begin
      nxt_cfg       = cfg_ff;
      nxt_value     = value_ff;
      nxt_flag      = flag_ff;
      nxt_lost      = lost_ff;
      nxt_latch     = latch_ff;
      nxt_unread    = unread_ff;
      nxt_pin       = pin_ff;
      nxt_prev      = sel_lvl;
      nxt_edge_dly  = edge_now;
      nxt_match     = match_now;
      nxt_wrap_flag = wrap_flag_ff;
      nxt_wrap_ie   = wrap_ie_ff;
      nxt_gie       = gie_ff;
      nxt_rdata     = rdata_ff;
      nxt_err       = err_ff;
      nxt_state     = state_ff;
      idx           = paddr[7:2];
      acc           = psel & penable & (state_ff == ccu_pkg::apb_wait_s);
      wr            = acc & pwrite;
      rd            = acc & ~pwrite;
      hit           = 1'b0;
      case (state_ff)
         ccu_pkg::apb_wait_s: nxt_state = acc ? ccu_pkg::apb_done_s : ccu_pkg::apb_wait_s;
         ccu_pkg::apb_done_s: nxt_state = ccu_pkg::apb_wait_s;
         default:             nxt_state = ccu_pkg::apb_wait_s;
      endcase
      nxt_pready = acc;
      if (acc)
      begin
         nxt_rdata = '0;
         if (idx == `CCU_IDX_CTL)
         begin
            hit = 1'b1;
            nxt_rdata[`CCU_F_GIE]       = gie_ff;
            nxt_rdata[`CCU_F_WRAP_IE]   = wrap_ie_ff;
            nxt_rdata[`CCU_F_WRAP_FLAG] = wrap_flag_ff;
            if (wr)
            begin
               nxt_gie       = pwdata[`CCU_F_GIE];
               nxt_wrap_ie   = pwdata[`CCU_F_WRAP_IE];
               nxt_wrap_flag = pwdata[`CCU_F_WRAP_FLAG];
            end
         end
         if (idx == `CCU_IDX_IV)
         begin
            hit = 1'b1;
            nxt_rdata[3:0] = vec;
            // read and write alike retire the source being reported
            if (vec == `CCU_VEC_WRAP)
               nxt_wrap_flag = 1'b0;
            else if (vec != `CCU_VEC_NONE)
               nxt_flag[vec[3:1]] = 1'b0;
         end
         for (int i = 0; i < N; i++)
         begin
            if (idx == 6'(`CCU_IDX_CCTL0 + 2 * i))
            begin
               hit = 1'b1;
               nxt_rdata[15:0] = pack_ctl(cfg_ff[i], sel_lvl[i], latch_ff[i], lost_ff[i], flag_ff[i]);
               if (wr)
               begin
                  nxt_cfg[i].edge_sel = pwdata[`CCU_F_EDGE+:2];
                  nxt_cfg[i].insel    = pwdata[`CCU_F_INSEL+:2];
                  nxt_cfg[i].sync_en  = pwdata[`CCU_F_SYNC];
                  nxt_cfg[i].meas     = pwdata[`CCU_F_MEAS];
                  nxt_cfg[i].wmode    = pwdata[`CCU_F_WMODE+:3];
                  nxt_cfg[i].ie       = pwdata[`CCU_F_IE];
                  nxt_cfg[i].manual   = pwdata[`CCU_F_MANUAL];
                  nxt_lost[i]         = pwdata[`CCU_F_LOST];
                  nxt_flag[i]         = pwdata[`CCU_F_FLAG];
               end
            end
            if (idx == 6'(`CCU_IDX_CCR0 + 2 * i))
            begin
               hit = 1'b1;
               nxt_rdata[15:0] = value_ff[i];
               if (wr)
                  nxt_value[i] = pwdata[15:0];
               if (rd)
                  nxt_unread[i] = 1'b0;
            end
         end
         nxt_err = ~hit;
      end
      if (irq0_ack)
         nxt_flag[0] = 1'b0;
      // hardware sets are applied last so they win over any clear this cycle
      if (wrap_pulse)
         nxt_wrap_flag = 1'b1;
      for (int i = 0; i < N; i++)
      begin
         if (cap_evt[i])
         begin
            nxt_value[i]  = count_val;
            nxt_flag[i]   = 1'b1;
            nxt_unread[i] = 1'b1;
            if (unread_ff[i])
               nxt_lost[i] = 1'b1;
         end
         if (match_now[i])
         begin
            nxt_flag[i]  = 1'b1;
            nxt_latch[i] = sel_lvl[i];
         end
         // pin is a flop: every mode moves on the clock edge, mode 0 one edge after the write
         case (ccu_pkg::wave_mode_t'(cfg_ff[i].wmode))
            ccu_pkg::wm_out:     nxt_pin[i] = cfg_ff[i].manual;
            ccu_pkg::wm_set:     nxt_pin[i] = match_now[i] | pin_ff[i];
            ccu_pkg::wm_rst:     nxt_pin[i] = ~match_now[i] & pin_ff[i];
            ccu_pkg::wm_tog:     nxt_pin[i] = match_now[i] ^ pin_ff[i];
            ccu_pkg::wm_tog_rst: nxt_pin[i] = ~period_match_pulse & (match_now[i] ^ pin_ff[i]);
            ccu_pkg::wm_set_rst: nxt_pin[i] = ~period_match_pulse & (match_now[i] | pin_ff[i]);
            ccu_pkg::wm_tog_set: nxt_pin[i] = period_match_pulse | (match_now[i] ^ pin_ff[i]);
            ccu_pkg::wm_rst_set: nxt_pin[i] = period_match_pulse | (~match_now[i] & pin_ff[i]);
            default:             nxt_pin[i] = pin_ff[i];
         endcase
         if (timer_clear && cfg_ff[i].wmode != 3'(ccu_pkg::wm_out))
            nxt_pin[i] = 1'b0;
      end
      nxt_irq0 = nxt_flag[0] & nxt_cfg[0].ie & nxt_gie;
      nxt_irqs = (|pend) & gie_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < N; i++)
         begin
            cfg_ff[i]   <= '0;
            value_ff[i] <= `CCU_RST_WORD;
         end
         flag_ff      <= '0;
         lost_ff      <= '0;
         latch_ff     <= '0;
         unread_ff    <= '0;
         pin_ff       <= '0;
         match_ff     <= '0;
         prev_ff      <= '0;
         edge_dly_ff  <= '0;
         wrap_flag_ff <= 1'b0;
         wrap_ie_ff   <= 1'b0;
         gie_ff       <= 1'b0;
         irq0_ff      <= 1'b0;
         irqs_ff      <= 1'b0;
         pready_ff    <= 1'b0;
         err_ff       <= 1'b0;
         rdata_ff     <= '0;
         state_ff     <= ccu_pkg::apb_wait_s;
      end
      else if (ce)
      begin
         cfg_ff       <= nxt_cfg;
         value_ff     <= nxt_value;
         flag_ff      <= nxt_flag;
         lost_ff      <= nxt_lost;
         latch_ff     <= nxt_latch;
         unread_ff    <= nxt_unread;
         pin_ff       <= nxt_pin;
         match_ff     <= nxt_match;
         prev_ff      <= nxt_prev;
         edge_dly_ff  <= nxt_edge_dly;
         wrap_flag_ff <= nxt_wrap_flag;
         wrap_ie_ff   <= nxt_wrap_ie;
         gie_ff       <= nxt_gie;
         irq0_ff      <= nxt_irq0;
         irqs_ff      <= nxt_irqs;
         pready_ff    <= nxt_pready;
         err_ff       <= nxt_err;
         rdata_ff     <= nxt_rdata;
         state_ff     <= nxt_state;
      end
   end

   assign prdata           = rdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = err_ff;
   assign chan_wave_pin    = pin_ff;
   assign chan_match_pulse = match_ff;
   assign irq_ch0          = irq0_ff;
   assign irq_shared       = irqs_ff;

   cap_copy_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && cap_evt[2]) |=> (value_ff[2] == $past(count_val) && flag_ff[2]))
      else $error("capture did not copy count and set flag");
   lost_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && cap_evt[2] && unread_ff[2]) |=> lost_ff[2])
      else $error("second capture did not set lost flag");
   sync_delay_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && edge_now[3] && cfg_ff[3].sync_en) ##1 (ce && cfg_ff[3].sync_en) |-> cap_evt[3])
      else $error("synchronised capture not one clock late");
   no_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && !count_step) |=> chan_match_pulse == '0)
      else $error("match without counter advance");
   match_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && !cfg_ff[1].meas && count_step && count_val == value_ff[1]) |=> (flag_ff[1] && chan_match_pulse[1]))
      else $error("compare match missed");
   set_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && cfg_ff[1].wmode == 3'h1 && (match_now[1] || chan_wave_pin[1]) && !timer_clear) |=> chan_wave_pin[1])
      else $error("set mode pin not held high");
   manual_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && cfg_ff[1].wmode == 3'h0) |=> chan_wave_pin[1] == $past(cfg_ff[1].manual))
      else $error("manual mode pin does not follow level bit");
   toggle_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && cfg_ff[1].wmode == 3'h4 && match_now[1] && !timer_clear) |=> chan_wave_pin[1] != $past(chan_wave_pin[1]))
      else $error("toggle mode did not toggle");
   period_clr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && cfg_ff[1].wmode == 3'h3 && period_match_pulse) |=> !chan_wave_pin[1])
      else $error("set/reset mode not cleared by period match");
   irq0_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && !gie_ff && !(wr && idx == `CCU_IDX_CTL)) |=> !irq_ch0)
      else $error("channel 0 irq without global enable");
   ack_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && irq0_ack && !cap_evt[0] && !match_now[0]) |=> !flag_ff[0])
      else $error("acknowledge did not clear channel 0 flag");
   vec_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ce && acc && idx == `CCU_IDX_IV && vec == 4'h6 && !cap_evt[3] && !match_now[3]) |=> (!flag_ff[3] && prdata[3:0] == 4'h6))
      else $error("vector access did not report and clear channel 3");
endmodule : capture_compare_channels

// ==== rtl/ccu_params.svh ====
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH
`define CCU_NCH         7
`define CCU_IDX_CTL     6'h00
`define CCU_IDX_CCTL0   6'h02
`define CCU_IDX_CCR0    6'h12
`define CCU_IDX_IV      6'h2E
`define CCU_F_EDGE      14
`define CCU_F_INSEL     12
`define CCU_F_SYNC      11
`define CCU_F_LATCH     10
`define CCU_F_MEAS      8
`define CCU_F_WMODE     5
`define CCU_F_IE        4
`define CCU_F_LEVEL     3
`define CCU_F_MANUAL    2
`define CCU_F_LOST      1
`define CCU_F_FLAG      0
`define CCU_F_WRAP_FLAG 0
`define CCU_F_WRAP_IE   1
`define CCU_F_GIE       2
`define CCU_RST_WORD    16'h0000
`define CCU_VEC_NONE    4'h0
`define CCU_VEC_WRAP    4'hE
`define CCU_SEL_A       2'h0
`define CCU_SEL_B       2'h1
`define CCU_SEL_GND     2'h2
`define CCU_EDGE_RISE   0
`define CCU_EDGE_FALL   1
`endif

// ==== rtl/ccu_pkg.sv ====
package ccu_pkg;
   typedef struct packed {
      logic [1:0] edge_sel;
      logic [1:0] insel;
      logic       sync_en;
      logic       meas;
      logic [2:0] wmode;
      logic       ie;
      logic       manual;
   } chan_cfg_t;
   typedef enum logic [2:0] {wm_out, wm_set, wm_tog_rst, wm_set_rst, wm_tog, wm_rst, wm_tog_set, wm_rst_set} wave_mode_t;
   typedef enum logic {apb_wait_s, apb_done_s} apb_state_t;
endpackage : ccu_pkg

// ==== verification/capture_source_model.sv ====
`timescale 1ns/1ps
// far-side sources: levels requested by the bench appear on the capture lines one edge later,
// so the design sees them as free-running signals behind its own synchronisers
module capture_source_model (
   input  wire logic       ref_clk,
   input  wire logic [6:0] want_a,
   input  wire logic [6:0] want_b,
   output logic      [6:0] sample_source_a,
   output logic      [6:0] sample_source_b
);
   logic [6:0] src_a_ff = 7'h00;
   logic [6:0] src_b_ff = 7'h00;

   always_ff @(posedge ref_clk)
   begin
      src_a_ff <= want_a;
      src_b_ff <= want_b;
   end

   assign sample_source_a = src_a_ff;
   assign sample_source_b = src_b_ff;
endmodule : capture_source_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "ccu_params.svh"
module tb_top;
   localparam logic       lo   = 1'b0;
   localparam logic       hi   = 1'b1;
   localparam logic [7:0] a_ctl = {`CCU_IDX_CTL, 2'b00};
   localparam logic [7:0] a_iv  = {`CCU_IDX_IV, 2'b00};
   logic        ref_clk;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic        pready, pslverr, irq_ch0, irq_shared;
   logic [15:0] count_val = 16'h0000;
   logic        count_step = 1'b0, period_match_pulse = 1'b0, wrap_pulse = 1'b0;
   logic        timer_clear = 1'b0, irq0_ack = 1'b0;
   logic [6:0]  want_a = 7'h00, want_b = 7'h00;
   logic [6:0]  sample_source_a, sample_source_b, chan_wave_pin, chan_match_pulse;
   logic [32:0] exp_q[$];
   logic [15:0] cnt, held, cmpv;
   int          n_fail = 0;
   int          tests_run = 0;

   capture_compare_channels capture_compare_channels_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_val(count_val), .count_step(count_step), .period_match_pulse(period_match_pulse),
      .wrap_pulse(wrap_pulse), .timer_clear(timer_clear), .sample_source_a(sample_source_a),
      .sample_source_b(sample_source_b), .irq0_ack(irq0_ack), .chan_wave_pin(chan_wave_pin),
      .chan_match_pulse(chan_match_pulse), .irq_ch0(irq_ch0), .irq_shared(irq_shared));

   capture_source_model capture_source_model_inst (
      .ref_clk(ref_clk), .want_a(want_a), .want_b(want_b),
      .sample_source_a(sample_source_a), .sample_source_b(sample_source_b));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      $display("tally: tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [7:0] a_cc(input int n);
      return {6'(`CCU_IDX_CCTL0 + 2 * n), 2'b00};
   endfunction : a_cc

   function automatic logic [7:0] a_cv(input int n);
      return {6'(`CCU_IDX_CCR0 + 2 * n), 2'b00};
   endfunction : a_cv

   function automatic logic [15:0] cw(input logic [1:0] e, s, input logic sy, lt, m, input logic [2:0] w,
                                      input logic ie, lv, mn, ls, fl);
      return {e, s, sy, lt, 1'b0, m, w, ie, lv, mn, ls, fl};
   endfunction : cw

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   // holds the request until pready is sampled, then releases at that same edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int k;
      k = 0;
      exp_q.push_back(e);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, pready, 1'b1);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      apb(1'b0, a, 32'h0000_0000, {17'h0_0000, e});
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d}, 33'h0_0000_0000);
   endtask : wr

   task automatic setcnt(input logic [15:0] v);
      @(posedge ref_clk);
      count_val <= v;
      cnt = v;
   endtask : setcnt

   // one cycle of counter events; returns just after the edge that registers the design's reaction
   task automatic tick(input logic [15:0] v, input logic st, pm, wp, cl);
      @(posedge ref_clk);
      count_val          <= v;
      count_step         <= st;
      period_match_pulse <= pm;
      wrap_pulse         <= wp;
      timer_clear        <= cl;
      @(posedge ref_clk);
      count_step         <= 1'b0;
      period_match_pulse <= 1'b0;
      wrap_pulse         <= 1'b0;
      timer_clear        <= 1'b0;
      #1;
   endtask : tick

   // read data is only meaningful on reads; pslverr is checked on every transfer
   always @(posedge ref_clk)
   begin
      if (reset_n === 1'b1 && psel && penable && pready === 1'b1)
         chk({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_q.pop_front());
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(30083));
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk({17'h0_0000, irq_ch0, irq_shared, chan_wave_pin, chan_match_pulse}, 33'h0_0000_0000);
      rd(a_ctl, 16'h0000);
      for (int n = 0; n < 7; n++)
      begin
         rd(a_cc(n), 16'h0000);
         rd(a_cv(n), 16'h0000);
      end
      rd(a_iv, 16'h0000);
      apb(1'b0, 8'h04, 32'h0000_0000, 33'h1_0000_0000);
      apb(1'b1, 8'h04, 32'h0000_FFFF, 33'h1_0000_0000);
      held = 16'h0000;
      for (int e = 0; e < 4; e++)
      begin
         setcnt(16'($urandom()));
         wr(a_cc(2), cw(2'(e), `CCU_SEL_A, e[0], lo, hi, 3'h0, lo, lo, lo, lo, lo));
         @(posedge ref_clk) want_a[2] <= 1'b1;
         cyc(6);
         if (e[0])
            held = cnt;
         rd(a_cc(2), cw(2'(e), `CCU_SEL_A, e[0], lo, hi, 3'h0, lo, hi, lo, lo, e[0]));
         rd(a_cv(2), held);
         wr(a_cc(2), cw(2'(e), `CCU_SEL_A, e[0], lo, hi, 3'h0, lo, lo, lo, lo, lo));
         setcnt(16'($urandom()));
         @(posedge ref_clk) want_a[2] <= 1'b0;
         cyc(6);
         if (e[1])
            held = cnt;
         rd(a_cc(2), cw(2'(e), `CCU_SEL_A, e[0], lo, hi, 3'h0, lo, lo, lo, lo, e[1]));
         rd(a_cv(2), held);
      end
      // two captures with no value read in between must flag the lost sample
      wr(a_cc(2), cw(2'h3, `CCU_SEL_A, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      @(posedge ref_clk) want_a[2] <= 1'b1;
      cyc(6);
      setcnt(16'($urandom()));
      @(posedge ref_clk) want_a[2] <= 1'b0;
      cyc(6);
      rd(a_cv(2), cnt);
      rd(a_cc(2), cw(2'h3, `CCU_SEL_A, hi, lo, hi, 3'h0, lo, lo, lo, hi, hi));
      wr(a_cc(2), cw(2'h3, `CCU_SEL_A, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      rd(a_cc(2), cw(2'h3, `CCU_SEL_A, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      // software capture by switching between ground and supply
      wr(a_cc(3), cw(2'h3, `CCU_SEL_GND, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      cyc(6);
      setcnt(16'($urandom()));
      wr(a_cc(3), cw(2'h3, 2'h3, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      cyc(6);
      rd(a_cv(3), cnt);
      wr(a_cc(3), cw(2'h3, `CCU_SEL_GND, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      cyc(6);
      setcnt(16'($urandom()));
      wr(a_cc(3), cw(2'h3, 2'h3, hi, lo, hi, 3'h0, lo, lo, lo, lo, lo));
      cyc(6);
      rd(a_cc(3), cw(2'h3, 2'h3, hi, lo, hi, 3'h0, lo, hi, lo, hi, hi));
      rd(a_cv(3), cnt);
      // compare channel 1, source b held high for the latched level
      @(posedge ref_clk) want_b[1] <= 1'b1;
      cmpv = 16'($urandom());
      wr(a_cv(1), cmpv);
      wr(a_cc(1), cw(2'h0, `CCU_SEL_B, lo, lo, lo, 3'h1, lo, lo, lo, lo, lo));
      tick(cmpv, lo, lo, lo, lo);
      chk(33'(chan_match_pulse[1]), 33'h0_0000_0000);
      for (int m = 1; m < 8; m++)
      begin
         wr(a_cc(1), cw(2'h0, `CCU_SEL_B, lo, lo, lo, 3'h7, lo, lo, lo, lo, lo));
         wr(a_cc(1), cw(2'h0, `CCU_SEL_B, lo, lo, lo, 3'(m), lo, lo, lo, lo, lo));
         tick(16'h0000, lo, lo, lo, hi);
         chk(33'(chan_wave_pin[1]), 33'h0_0000_0000);
         tick(cmpv, hi, lo, lo, lo);
         chk(33'(chan_match_pulse[1]), 33'h0_0000_0001);
         chk(33'(chan_wave_pin[1]), 33'(8'h5E >> m) & 33'h1);
         tick(16'h0000, lo, hi, lo, lo);
         chk(33'(chan_wave_pin[1]), 33'(8'hD2 >> m) & 33'h1);
         if (m == 4)
         begin
            tick(cmpv, hi, lo, lo, lo);
            chk(33'(chan_wave_pin[1]), 33'h0_0000_0000);
         end
      end
      rd(a_cc(1), cw(2'h0, `CCU_SEL_B, lo, hi, lo, 3'h7, lo, hi, lo, lo, hi));
      wr(a_cc(1), cw(2'h0, `CCU_SEL_B, lo, lo, lo, 3'h0, lo, lo, hi, lo, lo));
      #1;
      chk(33'(chan_wave_pin[1]), 33'h0_0000_0001);
      wr(a_cc(1), cw(2'h0, `CCU_SEL_B, lo, lo, lo, 3'h0, lo, lo, lo, lo, lo));
      #1;
      chk(33'(chan_wave_pin[1]), 33'h0_0000_0000);
      // interrupts: sources pending before the global enable is set
      wr(a_ctl, 16'h0002);
      wr(a_cc(0), cw(2'h0, 2'h0, lo, lo, lo, 3'h0, hi, lo, lo, lo, hi));
      wr(a_cc(3), cw(2'h0, 2'h0, lo, lo, lo, 3'h0, hi, lo, lo, lo, hi));
      wr(a_cc(4), cw(2'h0, 2'h0, lo, lo, lo, 3'h0, lo, lo, lo, lo, hi));
      wr(a_cc(5), cw(2'h0, 2'h0, lo, lo, lo, 3'h0, hi, lo, lo, lo, hi));
      tick(16'h0000, lo, lo, hi, lo);
      cyc(2);
      chk({31'h0, irq_ch0, irq_shared}, 33'h0_0000_0000);
      wr(a_ctl, 16'h0007);
      cyc(2);
      chk({31'h0, irq_ch0, irq_shared}, 33'h0_0000_0003);
      @(posedge ref_clk) irq0_ack <= 1'b1;
      @(posedge ref_clk) irq0_ack <= 1'b0;
      cyc(2);
      chk({31'h0, irq_ch0, irq_shared}, 33'h0_0000_0001);
      rd(a_iv, 16'h0006);
      cyc(2);
      chk(33'(irq_shared), 33'h0_0000_0001);
      wr(a_iv, 16'h0000);
      rd(a_iv, 16'h000E);
      rd(a_iv, 16'h0000);
      cyc(2);
      chk(33'(irq_shared), 33'h0_0000_0000);
      // a wrap pulse while the clock enable is low must leave the wrap flag clear
      @(posedge ref_clk);
      ce         <= 1'b0;
      wrap_pulse <= 1'b1;
      @(posedge ref_clk);
      wrap_pulse <= 1'b0;
      ce         <= 1'b1;
      rd(a_ctl, 16'h0006);
      cyc(2);
      tally_and_finish();
   end
endmodule : tb_top
